// ### hw/ieac_calc.sv
// Purpose: effective address for indexed, memory-indirect, PC modes
// Assumes: decoder holds request inputs stable while req_ready is low
// Notes:   one request at a time; one long-word read for indirection
`timescale 1ns/100ps
`include "ieac_defs.svh"

module ieac_calc #(
    parameter int ADDR_W = 32
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [2:0]        ea_mode,
    input  wire logic [2:0]        ea_reg,
    input  wire logic              is_write,
    input  wire logic [15:0]       ext_word,
    input  wire logic [31:0]       base_disp_in,
    input  wire logic [31:0]       outer_disp_in,
    input  wire logic [31:0]       ext_pc,
    input  wire logic [31:0]       base_addr_reg,
    input  wire logic [31:0]       index_reg,
    output logic                   rd_req,
    output logic [ADDR_W-1:0]      rd_addr,
    output logic                   rd_program,
    input  wire logic              rd_done,
    input  wire logic [31:0]       rd_data,
    output logic                   ea_valid,
    output logic [ADDR_W-1:0]      ea_addr,
    output logic                   ea_program,
    output logic                   ea_invalid
);
    // Only 32-bit address arithmetic is built
    if (ADDR_W != 32)
    begin : g_addr_w_check
        $error("ieac_calc serves only 32-bit addresses");
    end

    ieac_pkg::ieac_state_t state_q;
    ieac_pkg::ieac_ind_t   ind_q;
    ieac_pkg::ieac_ind_t   ind_d;
    logic [31:0] outer_q;
    logic [31:0] post_idx_q;
    logic [31:0] inter_d;
    logic [31:0] final_d;
    logic [31:0] base_v;
    logic [31:0] bd_v;
    logic [31:0] od_v;
    logic [31:0] byte_disp;
    logic        pc_mode;
    logic        full_fmt;
    logic        base_sup;
    logic        bad_d;
    logic        direct_d;
    logic [1:0]  bd_sz;
    logic [1:0]  od_sz;
    logic [2:0]  iis;

    ieac_idx_if idx ();

    ieac_idx_scale u_scale (
        .idx (idx)
    );

    // Extension word fields decoded once, shared by every form
    // Mode 111 register codes other than the PC forms are not decoded here
    assign pc_mode  = (ea_mode == `IEAC_MODE_EXT);
    assign full_fmt = ext_word[`IEAC_EXT_FULL_BIT];
    assign bd_sz    = ext_word[`IEAC_EXT_BDSZ_HI:`IEAC_EXT_BDSZ_LO];
    assign iis      = ext_word[`IEAC_EXT_IIS_HI:`IEAC_EXT_IIS_LO];
    assign od_sz    = iis[1:0];

    // Index register value is supplied by the decoder for the selected reg
    assign idx.raw     = index_reg;
    assign idx.word_sz = ~ext_word[`IEAC_EXT_WL_BIT];
    assign idx.scale   = ext_word[`IEAC_EXT_SCALE_HI:`IEAC_EXT_SCALE_LO];
    assign idx.suppress = full_fmt & ext_word[`IEAC_EXT_IS_BIT];

    assign base_sup = full_fmt & ext_word[`IEAC_EXT_BS_BIT];

    assign base_v = base_sup ? 32'h0
                  : (pc_mode ? ext_pc : base_addr_reg);

    assign byte_disp = {{24{ext_word[7]}}, ext_word[7:0]};

    // Reserved size code 00 adds zero, as null does
    // Base displacement size select
    always_comb
    begin
        bd_v = 32'h0;
        if (!full_fmt)
            bd_v = byte_disp;
        else if (bd_sz == `IEAC_SZ_WORD)
            bd_v = {{16{base_disp_in[15]}}, base_disp_in[15:0]};
        else if (bd_sz == `IEAC_SZ_LONG)
            bd_v = base_disp_in;
    end

    always_comb
    begin
        od_v = 32'h0;
        if (od_sz == `IEAC_SZ_WORD)
            od_v = {{16{outer_disp_in[15]}}, outer_disp_in[15:0]};
        else if (od_sz == `IEAC_SZ_LONG)
            od_v = outer_disp_in;
    end

    // Pick indirection kind and direct address
    // Reserved I/IS code 100 is taken as no indirection
    always_comb
    begin
        ind_d   = ieac_pkg::IEAC_IND_NONE;
        inter_d = 32'h0;
        final_d = 32'h0;
        if (pc_mode && ea_reg == `IEAC_REG_PC_DISP)
        begin
            final_d = ext_pc + {{16{ext_word[15]}}, ext_word};
        end
        else if (!full_fmt || iis[1:0] == 2'h0)
        begin
            final_d = base_v + bd_v + idx.scaled;
        end
        else if (iis[2])
        begin
            ind_d   = ieac_pkg::IEAC_IND_POST;
            inter_d = base_v + bd_v;
        end
        else
        begin
            ind_d   = ieac_pkg::IEAC_IND_PRE;
            inter_d = base_v + bd_v + idx.scaled;
        end
    end

    assign bad_d = pc_mode && is_write;

    // Refused and direct forms finish without a memory read
    assign direct_d = bad_d || (ind_d == ieac_pkg::IEAC_IND_NONE);

    // Combinational so the decoder sees ready in the idle cycle itself
    assign req_ready = (state_q == ieac_pkg::IEAC_IDLE);

    // One request in flight; ready stays low until back in idle

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state_q <= ieac_pkg::IEAC_IDLE;
        else
        begin
            unique case (state_q)
                ieac_pkg::IEAC_IDLE:
                    if (req_valid)
                        state_q <= ieac_pkg::IEAC_CALC;
                ieac_pkg::IEAC_CALC:
                    if (direct_d)
                        state_q <= ieac_pkg::IEAC_DONE;
                    else
                        state_q <= ieac_pkg::IEAC_FETCH;
                ieac_pkg::IEAC_FETCH:
                    if (rd_done)
                        state_q <= ieac_pkg::IEAC_DONE;
                ieac_pkg::IEAC_DONE:
                    state_q <= ieac_pkg::IEAC_IDLE;
                default:
                    state_q <= ieac_pkg::IEAC_IDLE;
            endcase
        end
    end

    // Latch operands at calc so the read may take any number of cycles
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ind_q      <= ieac_pkg::IEAC_IND_NONE;
            outer_q    <= 32'h0;
            post_idx_q <= 32'h0;
        end
        else if (state_q == ieac_pkg::IEAC_CALC)
        begin
            ind_q      <= ind_d;
            outer_q    <= od_v;
            post_idx_q <= idx.scaled;
        end
    end

    // Read address stays put while the read is outstanding
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_addr <= 32'h0;
        else if (state_q == ieac_pkg::IEAC_CALC)
            rd_addr <= inter_d;
    end

    // Level request, dropped on the edge that samples rd_done
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_req <= 1'b0;
        else if (state_q == ieac_pkg::IEAC_CALC)
            rd_req <= !direct_d;
        else if (rd_done)
            rd_req <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_program <= 1'b0;
        else if (state_q == ieac_pkg::IEAC_CALC)
            rd_program <= pc_mode;
    end

    // Result space flag
    // Flags change with the result, never while a read is in flight
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ea_program <= 1'b0;
            ea_invalid <= 1'b0;
        end
        else if (state_q == ieac_pkg::IEAC_CALC && direct_d)
        begin
            ea_program <= pc_mode;
            ea_invalid <= bad_d;
        end
        else if (state_q == ieac_pkg::IEAC_FETCH && rd_done)
        begin
            ea_program <= rd_program;
            ea_invalid <= 1'b0;
        end
    end

    // One-cycle result strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ea_valid <= 1'b0;
        else
            ea_valid <= (state_q == ieac_pkg::IEAC_CALC && direct_d)
                        || (state_q == ieac_pkg::IEAC_FETCH && rd_done);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ea_addr <= 32'h0;
        else if (state_q == ieac_pkg::IEAC_CALC && direct_d)
            ea_addr <= bad_d ? 32'h0 : final_d;
        else if (state_q == ieac_pkg::IEAC_FETCH && rd_done)
        begin
            // Post form adds index and outer
            // Pre form adds outer only; index sits in rd_addr
            ea_addr <= rd_data + outer_q
                       + ((ind_q == ieac_pkg::IEAC_IND_POST)
                          ? post_idx_q : 32'h0);
        end
    end
endmodule

// ### hw/ieac_idx_scale.sv
// Purpose: forms the sized, scaled, sign-extended index operand
// Assumes: scale code 0..3 means multiplier 1, 2, 4, 8
// Notes:   suppressed index yields zero
`timescale 1ns/100ps
module ieac_idx_scale (
    ieac_idx_if.unit idx
);
    logic [31:0] ext_w;

    assign ext_w = idx.word_sz ? {{16{idx.raw[15]}}, idx.raw[15:0]}
                               : idx.raw;
    assign idx.scaled = idx.suppress ? 32'h0 : (ext_w << idx.scale);
endmodule

// ### inc/ieac_defs.svh
// Purpose: constants for the indexed/indirect address calculator
// Assumes: effective address field and extension word layout of the core
// Notes:   definitions only
`ifndef IEAC_DEFS_SVH
`define IEAC_DEFS_SVH
`define IEAC_MODE_INDEX     3'h6
`define IEAC_MODE_EXT       3'h7
`define IEAC_REG_PC_DISP    3'h2
`define IEAC_REG_PC_INDEX   3'h3
`define IEAC_EXT_DA_BIT     15
`define IEAC_EXT_REG_HI     14
`define IEAC_EXT_REG_LO     12
`define IEAC_EXT_WL_BIT     11
`define IEAC_EXT_SCALE_HI   10
`define IEAC_EXT_SCALE_LO   9
`define IEAC_EXT_FULL_BIT   8
`define IEAC_EXT_BS_BIT     7
`define IEAC_EXT_IS_BIT     6
`define IEAC_EXT_BDSZ_HI    5
`define IEAC_EXT_BDSZ_LO    4
`define IEAC_EXT_IIS_HI     2
`define IEAC_EXT_IIS_LO     0
`define IEAC_SZ_NULL        2'h1
`define IEAC_SZ_WORD        2'h2
`define IEAC_SZ_LONG        2'h3
`endif

// ### inc/ieac_idx_if.sv
// Purpose: carries index operand to the scaling unit and back
// Assumes: single clock domain
// Notes:   combinational path only
`timescale 1ns/100ps
interface ieac_idx_if;
    logic [31:0] raw;
    logic        word_sz;
    logic [1:0]  scale;
    logic        suppress;
    logic [31:0] scaled;
    modport calc (output raw, output word_sz, output scale,
                  output suppress, input scaled);
    modport unit (input raw, input word_sz, input scale,
                  input suppress, output scaled);
endinterface

// ### inc/ieac_pkg.sv
// Purpose: types for the indexed/indirect address calculator
// Assumes: one processor clock domain
// Notes:   constants live in ieac_defs.svh
package ieac_pkg;
    typedef enum logic [3:0] {
        IEAC_IDLE  = 4'h1,
        IEAC_CALC  = 4'h2,
        IEAC_FETCH = 4'h4,
        IEAC_DONE  = 4'h8
    } ieac_state_t;
    typedef enum logic [1:0] {
        IEAC_IND_NONE = 2'h0,
        IEAC_IND_PRE  = 2'h1,
        IEAC_IND_POST = 2'h2
    } ieac_ind_t;
endpackage

// ### tb/ieac_calc_properties.sv
// Purpose: port timing and value checks for ieac_calc
// Assumes: one clock domain, reset active low
// Notes:   inputs held stable until ea_valid, so no $past is needed
`timescale 1ns/100ps
module ieac_calc_properties #(
    parameter int ADDR_W = 32
) (
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic [2:0]        ea_mode,
    input wire logic [2:0]        ea_reg,
    input wire logic              is_write,
    input wire logic [15:0]       ext_word,
    input wire logic [31:0]       ext_pc,
    input wire logic              rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic              rd_program,
    input wire logic              rd_done,
    input wire logic              ea_valid,
    input wire logic [ADDR_W-1:0] ea_addr,
    input wire logic              ea_program,
    input wire logic              ea_invalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic tk = req_valid && req_ready;
    wire logic pcm = tk && ea_mode == 3'h7 && ea_reg[2:1] == 2'h1;
    property p_brief_lat;
        tk && ea_mode == 3'h6 && !ext_word[8] |-> ##2 ea_valid;
    endproperty
    a_brief_lat: assert property (p_brief_lat)
        else $error("indexed result not on time");
    property p_pc_write;
        pcm && is_write |-> ##2 ea_valid && ea_invalid && ea_addr == 0;
    endproperty
    a_pc_write: assert property (p_pc_write)
        else $error("write with pc mode not flagged");
    property p_no_read;
        pcm && is_write |-> !rd_req ##1 !rd_req ##1 !rd_req;
    endproperty
    a_no_read: assert property (p_no_read)
        else $error("read issued for refused write");
    property p_pc_prog;
        pcm && !is_write |-> ##2 (ea_valid && ea_program)
            || (rd_req && rd_program);
    endproperty
    a_pc_prog: assert property (p_pc_prog)
        else $error("pc access not program space");
    property p_rd_hold;
        rd_req && !rd_done |=> rd_req && $stable(rd_addr);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read request dropped early");
    property p_ind_ans;
        rd_req && rd_done |=> ea_valid && !rd_req;
    endproperty
    a_ind_ans: assert property (p_ind_ans)
        else $error("no result after read");
    property p_pulse;
        ea_valid |=> !ea_valid && !rd_req;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("result pulse too long");
    property p_pc_disp;
        pcm && !ea_reg[0] && !is_write |-> ##2 ea_valid
            && ea_addr == ext_pc + {{16{ext_word[15]}}, ext_word};
    endproperty
    a_pc_disp: assert property (p_pc_disp)
        else $error("pc displacement address wrong");
    property p_all_sup;
        tk && ea_mode == 3'h6 && ext_word[8:4] == 5'h1D
            && ext_word[2:0] == 3'h0 |-> ##2 ea_valid && ea_addr == 0;
    endproperty
    a_all_sup: assert property (p_all_sup)
        else $error("empty index form not zero");
endmodule
bind ieac_calc ieac_calc_properties #(.ADDR_W(ADDR_W)) u_ieac_calc_properties
    (.clk_sys, .resetn, .req_valid, .req_ready, .ea_mode, .ea_reg,
     .is_write, .ext_word, .ext_pc, .rd_req, .rd_addr, .rd_program,
     .rd_done, .ea_valid, .ea_addr, .ea_program, .ea_invalid);

// ### tb/ieac_mem_model.sv
// Purpose: operand memory read port answering the calculator
// Assumes: data is address xor a fixed pattern
// Notes:   lat sets wait cycles; data is inverted once the read ends
`timescale 1ns/100ps
module ieac_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        rd_req,
    input  wire logic [31:0] rd_addr,
    input  wire logic [3:0]  lat,
    output logic             rd_done,
    output logic [31:0]      rd_data
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_done <= 1'b0;
            rd_data <= 32'h0;
            wait_q  <= 4'h0;
        end
        else if (rd_done)
        begin
            // Stale data must not look valid
            rd_done <= 1'b0;
            rd_data <= ~rd_data;
        end
        else if (rd_req && wait_q == lat)
        begin
            rd_done <= 1'b1;
            rd_data <= rd_addr ^ 32'hA5A50000;
            wait_q  <= 4'h0;
        end
        else if (rd_req)
            wait_q <= wait_q + 4'h1;
    end
endmodule

// ### tb/tb_ieac_calc.sv
// Purpose: directed scenarios for ieac_calc
// Assumes: inputs change at the falling edge
// Notes:   expected addresses worked out by hand
`timescale 1ns/100ps
module tb_ieac_calc;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        req_valid = 1'b0;
    logic [2:0]  ea_mode = 3'h0;
    logic [2:0]  ea_reg = 3'h0;
    logic        is_write = 1'b0;
    logic [15:0] ext_word = 16'h0;
    logic [31:0] bdi = 32'h0, odi = 32'h0, pci = 32'h0;
    logic [31:0] ari = 32'h0, ixi = 32'h0, seen_ra;
    logic [3:0]  lat = 4'h0;
    logic        seen_rp;
    wire logic   req_ready, rd_req, rd_program, rd_done;
    wire logic   ea_valid, ea_program, ea_invalid;
    wire logic [31:0] rd_addr, rd_data, ea_addr;
    int num_errors = 0;
    int n_compared = 0;
    ieac_calc u_ieac_calc (.clk_sys, .resetn, .req_valid, .req_ready,
        .ea_mode, .ea_reg, .is_write, .ext_word, .base_disp_in(bdi),
        .outer_disp_in(odi), .ext_pc(pci), .base_addr_reg(ari),
        .index_reg(ixi), .rd_req, .rd_addr, .rd_program, .rd_done,
        .rd_data, .ea_valid, .ea_addr, .ea_program, .ea_invalid);
    ieac_mem_model u_ieac_mem_model (.clk_sys, .resetn, .rd_req,
        .rd_addr, .lat, .rd_done, .rd_data);
    initial
        forever #4 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic run(input logic [2:0] m, r, input logic [15:0] e,
                       input logic [31:0] bd, od, pc, ar, ix);
        int i;
        @(negedge clk_sys);
        {ea_mode, ea_reg, ext_word, bdi, odi} = {m, r, e, bd, od};
        {pci, ari, ixi, req_valid, seen_rp} = {pc, ar, ix, 2'h2};
        seen_ra = 32'h0;
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (i = 0; i < 60 && ea_valid !== 1'b1; i++)
        begin
            seen_ra = (rd_req === 1'b1) ? rd_addr : seen_ra;
            seen_rp = (rd_req === 1'b1) ? rd_program : seen_rp;
            @(negedge clk_sys);
        end
        chk("ea_valid", ea_valid, 1'b1);
    endtask
    task automatic t_index;
        run(3'h6, 3'h1, 16'h24F0, 0, 0, 0, 32'h10000000, 32'h00018000);
        chk("brief", ea_addr, 32'h0FFDFFF0);
        run(3'h6, 3'h1, 16'h9F20, 32'h55558000, 0, 0, 32'h20000, 32'h10);
        chk("full", ea_addr, 32'h00018080);
        chk("prog", ea_program, 1'b0);
        chk("inv", ea_invalid, 1'b0);
    endtask
    task automatic t_suppress;
        run(3'h6, 3'h1, 16'h01D0, 32'hDEADBEEF, 0, 0, 32'h12345678, '1);
        chk("none", ea_addr, 32'h0);
        run(3'h6, 3'h1, 16'h3BB0, 32'h100, 0, 0, '1, 32'h40000001);
        chk("dreg", ea_addr, 32'h80000102);
    endtask
    task automatic t_indirect;
        lat = 4'h5;
        run(3'h6, 3'h0, 16'h0327, 32'hFFFC, 32'h10000, 0, 32'h1000, 'hFFFF);
        chk("post_rd", seen_ra, 32'h0FFC);
        chk("post_rp", seen_rp, 1'b0);
        chk("post", ea_addr, 32'hA5A60FFA);
        lat = 4'h0;
        run(3'h6, 3'h2, 16'hAD32, 32'h400, 32'h12348001, 0, 'h100000, 'h100);
        chk("pre_rd", seen_ra, 32'h00100800);
        chk("pre", ea_addr, 32'hA5B48801);
    endtask
    task automatic t_pc;
        run(3'h7, 3'h2, 16'hFFFE, 0, 0, 32'h4002, 0, 0);
        chk("pcd", ea_addr, 32'h4000);
        run(3'h7, 3'h3, 16'h187F, 0, 0, 32'h1000, 0, 32'h20);
        chk("pcx", ea_addr, 32'h109F);
        chk("pcx_prog", ea_program, 1'b1);
        run(3'h7, 3'h3, 16'h1920, 32'hFFF0, 0, 32'h1000, 0, 32'h20);
        chk("pcf", ea_addr, 32'h1010);
        run(3'h7, 3'h3, 16'h0B90, 0, 0, 32'h8000, '1, 32'h100);
        chk("zpcd", ea_addr, 32'h200);
        chk("zpcd_prog", ea_program, 1'b1);
        lat = 4'h2;
        run(3'h7, 3'h3, 16'h49A5, 32'h200, 'h77777777, 'h80000000, 0, 16);
        chk("zpc_rd", seen_ra, 32'h200);
        chk("zpc_prog", seen_rp, 1'b1);
        chk("zpc", ea_addr, 32'hA5A50210);
    endtask
    task automatic t_write;
        is_write = 1'b1;
        for (int r = 2; r < 4; r++)
        begin
            run(3'h7, r[2:0], 16'h187F, 0, 0, 32'h1000, 0, 32'h20);
            chk("wr_inv", ea_invalid, 1'b1);
            chk("wr_addr", ea_addr, 32'h0);
        end
        run(3'h6, 3'h1, 16'h24F0, 0, 0, 0, 32'h10000000, 32'h00018000);
        chk("wr_ok", ea_invalid, 1'b0);
        chk("wr_ok_addr", ea_addr, 32'h0FFDFFF0);
        is_write = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(negedge clk_sys);
        chk("rst_ready", req_ready, 1'b1);
        chk("rst_valid", ea_valid, 1'b0);
        resetn = 1'b1;
        t_index();
        t_suppress();
        t_indirect();
        t_pc();
        t_write();
        report_and_stop();
    end
endmodule
